// ### core/rcr_pkg.sv
/*
 * Shared constants and types for the reset cause recorder: register map,
 * field positions, reset values, vectors and the carrier structs.
 * Assumes a 32-bit AXI4-Lite register bus with 4-bit byte addresses.
 */
package rcr_pkg;

   // Register map, byte addresses
   localparam int unsigned ADDR_W         = 4;
   localparam logic [3:0]  OFS_STATUS     = 4'h0;
   localparam logic [3:0]  OFS_POWER_CTRL = 4'h4;
   localparam logic [3:0]  OFS_RESET_INFO = 4'h8;
   localparam logic [3:0]  OFS_CONTROL    = 4'hC;

   // Field positions
   localparam int unsigned STAT_TO_BIT    = 4;
   localparam int unsigned STAT_PD_BIT    = 3;
   localparam int unsigned POWER_CONTROL_REG_POR_BIT   = 1;
   localparam int unsigned POWER_CONTROL_REG_BOR_BIT   = 0;
   localparam int unsigned CTRL_WAIT_BIT  = 0;
   localparam int unsigned INFO_HOLD_BIT  = 8;
   localparam logic [31:0] STATUS_MASK    = 32'h0000_0018;

   // Reset values
   localparam logic        CTRL_WAIT_RST  = 1'b1;

   // Bus responses
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // Program counter targets
   localparam logic [15:0] RESET_VECTOR   = 16'h0000;
   localparam logic [15:0] IRQ_VECTOR     = 16'h0004;

   typedef struct packed {
      logic por;
      logic ldo;
      logic bor;
      logic wdt;
      logic master_clear_pin;
      logic irq_wake;
   } rcr_events_t;

   typedef struct packed {
      logic poweron_flag_n;
      logic brownout_flag_n;
      logic timeout_flag_n;
      logic powerdown_flag_n;
   } rcr_flags_t;

   // Brown-out flag is undefined at power-on; it is taken as set
   localparam rcr_flags_t FLAGS_POR_VALUE = 4'h7;

   typedef enum logic [2:0] {
      CAUSE_NONE,
      CAUSE_POR,
      CAUSE_BOR,
      CAUSE_WDT_RST,
      CAUSE_MASTER_CLEAR_PIN_RUN,
      CAUSE_MASTER_CLEAR_PIN_SLEEP,
      CAUSE_WDT_WAKE,
      CAUSE_IRQ_WAKE
   } rcr_cause_t;

endpackage

// ### core/rcr_flag_next.sv
/*
 * Combinational decode of reset and wake events into the next flag
 * values and a cause code. Assumes events are one-cycle pulses that are
 * synchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module rcr_flag_next
   import rcr_pkg::*;
(
   input  wire rcr_pkg::rcr_events_t ev,
   input  wire logic                 sleeping,
   input  wire rcr_pkg::rcr_flags_t  flags,
   output rcr_pkg::rcr_flags_t       flags_next,
   output rcr_pkg::rcr_cause_t       cause,
   output logic                      is_reset,
   output logic                      is_wake
);

   // Power loss dominates everything, then brown-out, then the rest
   always_comb begin
      flags_next = flags;
      cause      = CAUSE_NONE;
      if (ev.por || ev.ldo) begin
         flags_next.poweron_flag_n   = 1'b0;
         flags_next.timeout_flag_n   = 1'b1;
         flags_next.powerdown_flag_n = 1'b1;
         cause                       = CAUSE_POR;
      end else if (ev.bor) begin
         flags_next.brownout_flag_n  = 1'b0;
         flags_next.timeout_flag_n   = 1'b1;
         flags_next.powerdown_flag_n = 1'b1;
         cause                       = CAUSE_BOR;
      end else if (ev.wdt && !sleeping) begin
         flags_next.timeout_flag_n   = 1'b0;
         flags_next.powerdown_flag_n = 1'b1;
         cause                       = CAUSE_WDT_RST;
      end else if (ev.master_clear_pin && !sleeping) begin
         cause                       = CAUSE_MASTER_CLEAR_PIN_RUN;
      end else if (ev.master_clear_pin) begin
         flags_next.timeout_flag_n   = 1'b1;
         flags_next.powerdown_flag_n = 1'b0;
         cause                       = CAUSE_MASTER_CLEAR_PIN_SLEEP;
      end else if (ev.wdt) begin
         flags_next.timeout_flag_n   = 1'b0;
         flags_next.powerdown_flag_n = 1'b0;
         cause                       = CAUSE_WDT_WAKE;
      end else if (ev.irq_wake && sleeping) begin
         flags_next.timeout_flag_n   = 1'b1;
         flags_next.powerdown_flag_n = 1'b0;
         cause                       = CAUSE_IRQ_WAKE;
      end
      is_reset = (cause == CAUSE_POR) || (cause == CAUSE_BOR) || (cause == CAUSE_WDT_RST) ||
                 (cause == CAUSE_MASTER_CLEAR_PIN_RUN) || (cause == CAUSE_MASTER_CLEAR_PIN_SLEEP);
      is_wake  = (cause == CAUSE_WDT_WAKE) || (cause == CAUSE_IRQ_WAKE);
   end

endmodule

`default_nettype wire

// ### core/rcr_cap_hold.sv
/*
 * Holds the core in reset while the regulator bypass capacitor charges.
 * Assumes the charged indication is synchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module rcr_cap_hold (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic start,
   input  wire logic wait_en,
   input  wire logic charged,
   output logic      hold_q,
   output logic      charge_q
);

   typedef enum logic {ST_CHARGE, ST_RUN} rcr_cap_state_t;

   rcr_cap_state_t state_q;
   rcr_cap_state_t state_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (start) begin
               state_d = ST_CHARGE;
            end
         end
         ST_CHARGE: begin
            if (!wait_en || charged) begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_CHARGE;
      endcase
   end

   // Power-up enters the charge wait, so the core never starts on a flat cap
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q  <= ST_CHARGE;
         hold_q   <= 1'b1;
         charge_q <= 1'b1;
      end else begin
         state_q  <= state_d;
         hold_q   <= (state_d == ST_CHARGE);
         charge_q <= (state_d == ST_CHARGE) && wait_en;
      end
   end

endmodule

`default_nettype wire

// ### core/rcr_top.sv
/*
 * Reset cause recorder: keeps the timeout, power-down, power-on and
 * brown-out flags, steers the program counter after resets and wakes,
 * and holds the core in reset while the regulator capacitor charges.
 * Assumes all event inputs are single-cycle pulses synchronous to aclk
 * and an AXI4-Lite master that keeps to the protocol.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - A power-on or regulator reset clears the power-on flag and sets the timeout and power-down flags.
// - The timeout flag is always set on power-on, so the power-on flag never clears together with a cleared timeout.
// - The power-down flag is always set on power-on, so the power-on flag never clears together with a cleared power-down.
// - Brown-out clears its flag and sets timeout and power-down, watchdog reset clears timeout, watchdog wake clears both.
// - A master-clear reset while running leaves all four flags as they were.
// - Master-clear in sleep or interrupt wake sets timeout, clears power-down and keeps power-on and brown-out.
// - Power-on, brown-out, watchdog and master-clear resets restart the program counter at address 0000h.
// - A watchdog or interrupt wake from sleep continues at the instruction after the sleep.
// - An interrupt wake with interrupts enabled runs one instruction, then pushes the return address and jumps to 0004h.
// - Flag positions with no implemented bit read as zero.
// - On power-up with the regulator in use, reset is held while the bypass capacitor charges.
// - With the control wait bit set, internal reset is released only after the bypass capacitor is seen fully charged; with it clear, at once.
module rcr_top
   import rcr_pkg::*;
#(
   parameter int unsigned PC_W = 13
) (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [rcr_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   input  wire logic [rcr_pkg::ADDR_W-1:0] araddr,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   input  wire rcr_pkg::rcr_events_t       reset_events,
   input  wire logic                       cpu_sleeping,
   input  wire logic                       global_irq_enable,
   input  wire logic [PC_W-1:0]            pc_current,
   input  wire logic                       instr_retired,
   input  wire logic                       regulator_cap_charged,
   output logic                            regulator_cap_charge,
   output logic                            core_reset_n,
   output logic                            pc_load,
   output logic [PC_W-1:0]                 pc_load_addr,
   output logic                            ret_push,
   output logic [PC_W-1:0]                 ret_addr
);
   import rcr_pkg::*;

   if (PC_W < 3 || PC_W > 16) begin : g_bad_pc_w
      $error("PC_W must lie between 3 and 16");
   end

   localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);
   localparam logic [PC_W-1:0] PC_TWO = PC_W'(2);

   function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
      addr_mapped = (a == OFS_STATUS) || (a == OFS_POWER_CTRL) ||
                    (a == OFS_RESET_INFO) || (a == OFS_CONTROL);
   endfunction

   rcr_flags_t        flags_q;
   rcr_flags_t        flags_d;
   rcr_cause_t        cause_d;
   rcr_cause_t        cause_q;
   logic              evt_reset;
   logic              evt_wake;
   logic              evt_any;
   logic              ctrl_wait_q;
   logic              hold;
   logic              awready_q;
   logic              wready_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              arready_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   logic [1:0]        rresp_q;
   logic              aw_full_q;
   logic              w_full_q;
   logic [ADDR_W-1:0] waddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              rd_status_q;
   logic              core_reset_n_q;
   logic              pc_load_q;
   logic [PC_W-1:0]   pc_load_addr_q;
   logic              ret_push_q;
   logic [PC_W-1:0]   ret_addr_q;
   logic              irq_pend_q;
   logic              charge_q;

   rcr_flag_next u_flag_next (
      .ev         (reset_events),
      .sleeping   (cpu_sleeping),
      .flags      (flags_q),
      .flags_next (flags_d),
      .cause      (cause_d),
      .is_reset   (evt_reset),
      .is_wake    (evt_wake)
   );

   assign evt_any = evt_reset || evt_wake;

   rcr_cap_hold u_cap_hold (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .start    (reset_events.por || reset_events.ldo),
      .wait_en  (ctrl_wait_q),
      .charged  (regulator_cap_charged),
      .hold_q   (hold),
      .charge_q (charge_q)
   );

   // Write channel: address and data are accepted in either order
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic aw_full_d;
   logic w_full_d;
   logic power_control_reg_wr;
   logic ctrl_wr;

   assign aw_take   = awvalid && awready_q;
   assign w_take    = wvalid && wready_q;
   assign wr_fire   = aw_full_q && w_full_q && !bvalid_q;
   assign aw_full_d = (aw_full_q || aw_take) && !wr_fire;
   assign w_full_d  = (w_full_q || w_take) && !wr_fire;
   assign power_control_reg_wr   = wr_fire && (waddr_q == OFS_POWER_CTRL) && wstrb_q[0];
   assign ctrl_wr   = wr_fire && (waddr_q == OFS_CONTROL) && wstrb_q[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         waddr_q   <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         awready_q <= !aw_full_d;
         wready_q  <= !w_full_d;
         if (aw_take) begin
            waddr_q <= awaddr;
         end
         if (w_take) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q  <= addr_mapped(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read channel: one read in flight, answered one cycle after acceptance
   logic        ar_take;
   logic        rvalid_d;
   logic [31:0] rd_word;

   assign ar_take  = arvalid && arready_q;
   assign rvalid_d = (rvalid_q && !rready) || ar_take;

   always_comb begin
      rd_word = '0;
      case (araddr)
         OFS_STATUS: begin
            rd_word[STAT_TO_BIT] = flags_q.timeout_flag_n;
            rd_word[STAT_PD_BIT] = flags_q.powerdown_flag_n;
         end
         OFS_POWER_CTRL: begin
            rd_word[POWER_CONTROL_REG_POR_BIT] = flags_q.poweron_flag_n;
            rd_word[POWER_CONTROL_REG_BOR_BIT] = flags_q.brownout_flag_n;
         end
         OFS_RESET_INFO: begin
            rd_word[2:0]           = cause_q;
            rd_word[INFO_HOLD_BIT] = hold;
         end
         OFS_CONTROL: begin
            rd_word[CTRL_WAIT_BIT] = ctrl_wait_q;
         end
         default: rd_word = '0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q   <= 1'b0;
         rvalid_q    <= 1'b0;
         rdata_q     <= '0;
         rresp_q     <= RESP_OKAY;
         rd_status_q <= 1'b0;
      end else begin
         arready_q <= !rvalid_d;
         rvalid_q  <= rvalid_d;
         if (ar_take) begin
            rdata_q     <= rd_word;
            rresp_q     <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            rd_status_q <= (araddr == OFS_STATUS);
         end
      end
   end

   // Flags: an event in the same cycle as a software write wins.
   // Software can only set the power-control flags, never clear them,
   // so a cleared flag always traces back to a real event.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= FLAGS_POR_VALUE;
      end else if (evt_any) begin
         flags_q <= flags_d;
      end else if (power_control_reg_wr) begin
         flags_q.poweron_flag_n  <= flags_q.poweron_flag_n || wdata_q[POWER_CONTROL_REG_POR_BIT];
         flags_q.brownout_flag_n <= flags_q.brownout_flag_n || wdata_q[POWER_CONTROL_REG_BOR_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause_q     <= CAUSE_POR;
         ctrl_wait_q <= CTRL_WAIT_RST;
      end else begin
         if (evt_any) begin
            cause_q <= cause_d;
         end
         if (ctrl_wr) begin
            ctrl_wait_q <= wdata_q[CTRL_WAIT_BIT];
         end
      end
   end

   // Core reset follows the charge hold and pulses for every reset event
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_reset_n_q <= 1'b0;
      end else begin
         core_reset_n_q <= !(hold || evt_reset);
      end
   end

   // Program counter steering
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_load_q      <= 1'b0;
         pc_load_addr_q <= RESET_VECTOR[PC_W-1:0];
         ret_push_q     <= 1'b0;
         ret_addr_q     <= '0;
         irq_pend_q     <= 1'b0;
      end else begin
         pc_load_q  <= 1'b0;
         ret_push_q <= 1'b0;
         if (evt_reset) begin
            pc_load_q      <= 1'b1;
            pc_load_addr_q <= RESET_VECTOR[PC_W-1:0];
            irq_pend_q     <= 1'b0;
         end else if (evt_wake) begin
            pc_load_q      <= 1'b1;
            pc_load_addr_q <= PC_W'(pc_current + PC_ONE);
            irq_pend_q     <= (cause_d == CAUSE_IRQ_WAKE) && global_irq_enable;
            ret_addr_q     <= PC_W'(pc_current + PC_TWO);
         end else if (irq_pend_q && instr_retired) begin
            // Vector only after the instruction after sleep has run
            pc_load_q      <= 1'b1;
            pc_load_addr_q <= IRQ_VECTOR[PC_W-1:0];
            ret_push_q     <= 1'b1;
            irq_pend_q     <= 1'b0;
         end
      end
   end

   assign awready              = awready_q;
   assign wready               = wready_q;
   assign bvalid               = bvalid_q;
   assign bresp                = bresp_q;
   assign arready              = arready_q;
   assign rvalid               = rvalid_q;
   assign rdata                = rdata_q;
   assign rresp                = rresp_q;
   assign core_reset_n         = core_reset_n_q;
   assign regulator_cap_charge = charge_q;
   assign pc_load              = pc_load_q;
   assign pc_load_addr         = pc_load_addr_q;
   assign ret_push             = ret_push_q;
   assign ret_addr             = ret_addr_q;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic high_ev;
   assign high_ev = reset_events.por || reset_events.ldo || reset_events.bor;

   chk_por_flags: assert property ((reset_events.por || reset_events.ldo) |=>
      !flags_q.poweron_flag_n && flags_q.timeout_flag_n && flags_q.powerdown_flag_n)
      else $error("power-on did not give the power-on flag pattern");
   chk_por_timeout: assert property ($fell(flags_q.poweron_flag_n) |-> flags_q.timeout_flag_n)
      else $error("power-on flag cleared with timeout flag clear");
   chk_por_pdown: assert property ($fell(flags_q.poweron_flag_n) |-> flags_q.powerdown_flag_n)
      else $error("power-on flag cleared with power-down flag clear");
   chk_bor_flags: assert property ((reset_events.bor && !reset_events.por && !reset_events.ldo) |=>
      !flags_q.brownout_flag_n && flags_q.timeout_flag_n && flags_q.powerdown_flag_n &&
      $stable(flags_q.poweron_flag_n))
      else $error("brown-out flag pattern wrong");
   // A master-clear in sleep outranks a watchdog wake in the same cycle
   chk_wdt_reset: assert property ((reset_events.wdt && !high_ev && !(reset_events.master_clear_pin && cpu_sleeping)) |=>
      !flags_q.timeout_flag_n && (flags_q.powerdown_flag_n == !$past(cpu_sleeping)))
      else $error("watchdog flag pattern wrong");
   chk_master_clear_pin_run: assert property ((reset_events.master_clear_pin && !cpu_sleeping && !high_ev && !reset_events.wdt)
      |=> $stable(flags_q))
      else $error("running master-clear changed a flag");
   chk_sleep_wake: assert property ((cpu_sleeping && !high_ev && !reset_events.wdt &&
      (reset_events.master_clear_pin || reset_events.irq_wake)) |=> flags_q.timeout_flag_n &&
      !flags_q.powerdown_flag_n && $stable(flags_q.poweron_flag_n) && $stable(flags_q.brownout_flag_n))
      else $error("sleep wake flag pattern wrong");
   chk_pc_vector: assert property (evt_reset |=> pc_load_q && (pc_load_addr_q == RESET_VECTOR[PC_W-1:0]) &&
      !core_reset_n_q)
      else $error("reset did not restart at the reset vector");
   chk_pc_resume: assert property (evt_wake |=> pc_load_q && (pc_load_addr_q == $past(pc_current) + PC_ONE))
      else $error("wake did not resume after the sleep");
   chk_irq_vector: assert property ((irq_pend_q && instr_retired && !evt_any) |=>
      ret_push_q && pc_load_q && (pc_load_addr_q == IRQ_VECTOR[PC_W-1:0]) ##1 !ret_push_q)
      else $error("interrupt wake did not vector correctly");
   chk_zero_bits: assert property ((rvalid_q && rd_status_q) |-> ((rdata_q & ~STATUS_MASK) == 32'h0000_0000))
      else $error("unimplemented status bits read nonzero");
   chk_hold_reset: assert property (hold |=> !core_reset_n_q)
      else $error("core released while capacitor charges");
   chk_cap_release: assert property ($fell(hold) |-> ($past(regulator_cap_charged) || !$past(ctrl_wait_q)))
      else $error("hold dropped before the capacitor charged");
   chk_flag_keep: assert property ((!evt_any && !power_control_reg_wr) |=> $stable(flags_q))
      else $error("flag changed with no cause");

endmodule

`default_nettype wire

// ### bench/tb_top.sv
/*
 * Self-checking bench for the reset cause recorder: AXI4-Lite register
 * tasks, event pulses and expected flag, cause and program counter values.
 * Assumes the recorder package and top module are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import rcr_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, cpu_sleeping = 1'b0, global_irq_enable = 1'b0;
   logic instr_retired = 1'b0, regulator_cap_charged = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, regulator_cap_charge, core_reset_n, pc_load, ret_push;
   logic [12:0] pc_current = 13'h0123, pc_load_addr, ret_addr;
   rcr_events_t reset_events = '0;
   int n_mismatch = 0, total_checks = 0;

   always #2.5 aclk = ~aclk;

   rcr_top #(.PC_W(13)) DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .reset_events, .cpu_sleeping, .global_irq_enable, .pc_current, .instr_retired,
      .regulator_cap_charged, .regulator_cap_charge, .core_reset_n, .pc_load, .pc_load_addr,
      .ret_push, .ret_addr);

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Registered readies are sampled in the active region, before the edge's updates land
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      while (n < 50) begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      bready <= 1'b0;
      if (n >= 50) begin n_mismatch++; wrap_up(); end
      else chk("bresp", 32'(er), 32'(bresp));
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] er = RESP_OKAY);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      while (n < 50) begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      rready <= 1'b0;
      if (n >= 50) begin n_mismatch++; wrap_up(); end
      else begin
         chk("rdata", e, rdata & m);
         chk("rresp", 32'(er), 32'(rresp));
      end
   endtask

   // One event pulse; outputs are looked at one edge after the take
   task automatic step(input logic [5:0] e, input logic s, input logic [31:0] st, pcn, cs,
                       input logic [12:0] pa);
      cpu_sleeping <= s; reset_events <= rcr_events_t'(e);
      @(posedge aclk);
      reset_events <= '0;
      @(posedge aclk);
      chk("pc_load", 32'h1, 32'(pc_load));
      chk("pc_load_addr", 32'(pa), 32'(pc_load_addr));
      chk("core_reset_n", 32'(pa != 13'h0), 32'(core_reset_n));
      cpu_sleeping <= 1'b0;
      rd(OFS_STATUS, st, 32'hFFFF_FFFF);
      rd(OFS_POWER_CTRL, pcn, 32'hFFFF_FFFF);
      rd(OFS_RESET_INFO, cs, 32'h7);
   endtask

   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
      chk("hold", 32'h0, 32'(core_reset_n));
      chk("charge", 32'h1, 32'(regulator_cap_charge));
      rd(OFS_STATUS, 32'h18, 32'hFFFF_FFFF);
      rd(OFS_POWER_CTRL, 32'h1, 32'hFFFF_FFFF);
      regulator_cap_charged <= 1'b1;
      repeat (2) @(posedge aclk);
      chk("early release", 32'h0, 32'(core_reset_n));
      @(posedge aclk);
      chk("release", 32'h1, 32'(core_reset_n));
      chk("charge off", 32'h0, 32'(regulator_cap_charge));
      // Read-only status ignores writes; software can only set power flags
      wr(OFS_STATUS, 32'h0);
      wr(OFS_POWER_CTRL, 32'h3);
      wr(OFS_POWER_CTRL, 32'h0);
      rd(OFS_STATUS, 32'h18, 32'hFFFF_FFFF);
      rd(OFS_POWER_CTRL, 32'h3, 32'hFFFF_FFFF);
      step(6'h08, 1'b0, 32'h18, 32'h2, 32'h2, 13'h0);
      step(6'h04, 1'b0, 32'h08, 32'h2, 32'h3, 13'h0);
      step(6'h02, 1'b0, 32'h08, 32'h2, 32'h4, 13'h0);
      step(6'h02, 1'b1, 32'h10, 32'h2, 32'h5, 13'h0);
      step(6'h04, 1'b1, 32'h00, 32'h2, 32'h6, 13'h0124);
      step(6'h01, 1'b1, 32'h10, 32'h2, 32'h7, 13'h0124);
      step(6'h10, 1'b0, 32'h18, 32'h0, 32'h1, 13'h0);
      // Power-on with a flat capacitor: held until the wait is lifted
      regulator_cap_charged <= 1'b0;
      step(6'h20, 1'b0, 32'h18, 32'h0, 32'h1, 13'h0);
      rd(OFS_RESET_INFO, 32'h101, 32'h107);
      chk("held", 32'h0, 32'(core_reset_n));
      chk("charging", 32'h1, 32'(regulator_cap_charge));
      wr(OFS_CONTROL, 32'h0);
      rd(OFS_CONTROL, 32'h0, 32'hFFFF_FFFF);
      chk("no wait", 32'h1, 32'(core_reset_n));
      wr(OFS_CONTROL, 32'h1);
      regulator_cap_charged <= 1'b1;
      wr(4'h1, 32'h3, RESP_SLVERR);
      rd(4'h1, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
      repeat (6) @(posedge aclk);
      global_irq_enable <= 1'b1;
      step(6'h01, 1'b1, 32'h10, 32'h0, 32'h7, 13'h0124);
      instr_retired <= 1'b1;
      @(posedge aclk);
      instr_retired <= 1'b0;
      @(posedge aclk);
      chk("vector", 32'h4, 32'(pc_load_addr));
      chk("ret_push", 32'h1, 32'(ret_push));
      chk("ret_addr", 32'h0125, 32'(ret_addr));
      wrap_up();
   end
endmodule

`default_nettype wire
